// *** spm_pin_mux.sv ***
// pin select register with apb access and the serial port / address pin routing
`timescale 1ns/100ps
`include "spm_params.svh"
module spm_pin_mux #(
  parameter int unsigned AW = 12
) (
  input  wire logic                i_mclk,
  input  wire logic                i_rst_n,
  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------
  input  wire logic                i_psel,
  input  wire logic                i_penable,
  input  wire logic                i_pwrite,
  input  wire logic [AW-1:0]       i_paddr,
  input  wire logic [31:0]         i_pwdata,
  output logic [31:0]              o_prdata,
  output logic                     o_pready,
  output logic                     o_pslverr,
  // ---------------------------------------------------------------
  // serial ports, index 0 and 1
  // ---------------------------------------------------------------
  input  wire spm_pkg::spm_drv6_t  i_card_drv  [2],
  output logic [5:0]               o_card_in   [2],
  input  wire spm_pkg::spm_drv4_t  i_audio_drv [2],
  output logic [3:0]               o_audio_in  [2],
  input  wire spm_pkg::spm_drv6_t  i_spgp_drv  [2],
  output logic [5:0]               o_spgp_in   [2],
  output spm_pkg::spm_pad6_t       o_sp_pad    [2],
  input  wire logic [5:0]          i_sp_pad_in [2],
  // ---------------------------------------------------------------
  // upper address pins, bit 0 is address 15 / gp 21
  // ---------------------------------------------------------------
  input  wire logic [5:0]          i_ema_hi,
  input  wire logic                i_ema_oe,
  input  wire spm_pkg::spm_drv6_t  i_adgp_drv,
  output logic [5:0]               o_adgp_in,
  output spm_pkg::spm_pad6_t       o_addr_pad,
  input  wire logic [5:0]          i_addr_pad_in
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  spm_pkg::spm_state_t st_q;
  spm_pkg::spm_state_t st_d;

  logic        hit;
  logic        setup;
  logic        wr_acc;
  logic [15:0] sel_view;
  logic [1:0]  wr_sp1;
  logic [1:0]  wr_sp0;

  // one register, decoded once into hit and reused
  function automatic logic addr_hit(input logic [AW-1:0] a);
    addr_hit = (a == AW'(`SPM_SEL_OFFSET));
  endfunction

  // reserved bits and unmodelled upper field read as zero
  assign sel_view = {4'h0, st_q.sp1, st_q.sp0, 2'h0, st_q.addr} & `SPM_SEL_RDMASK;

  assign hit    = addr_hit(i_paddr);
  assign setup  = i_psel && !i_penable;
  assign wr_acc = i_psel && i_penable && i_pwrite && hit;
  assign wr_sp1 = i_pwdata[`SPM_SP1_LSB +: 2];
  assign wr_sp0 = i_pwdata[`SPM_SP0_LSB +: 2];

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    case (st_q.phase)
      spm_pkg::SPM_PH_IDLE: begin
        if (setup) begin
          st_d.phase = spm_pkg::SPM_PH_ACCESS;
          st_d.err   = !hit;
          // read data captured in setup so it leaves a flop
          if (hit && !i_pwrite) begin
            st_d.rdata = {16'h0000, sel_view};
          end else begin
            st_d.rdata = 32'h0000_0000;
          end
        end
      end
      spm_pkg::SPM_PH_ACCESS: begin
        if (i_psel && i_penable) begin
          st_d.phase = spm_pkg::SPM_PH_IDLE;
        end else if (!i_psel) begin
          st_d.phase = spm_pkg::SPM_PH_IDLE;
        end
      end
      default: begin
        st_d.phase = spm_pkg::SPM_PH_IDLE;
      end
    endcase
    if (wr_acc) begin
      // reserved code would leave pins floating; keep the old route instead
      if (wr_sp1 != 2'h3) begin
        st_d.sp1 = spm_pkg::spm_route_t'(wr_sp1);
      end
      if (wr_sp0 != 2'h3) begin
        st_d.sp0 = spm_pkg::spm_route_t'(wr_sp0);
      end
      // bits 7:6 never reach state
      st_d.addr = i_pwdata[`SPM_ADDR_LSB +: 6];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      st_q.sp1   <= spm_pkg::spm_route_t'(`SPM_MODE_RESET);
      st_q.sp0   <= spm_pkg::spm_route_t'(`SPM_MODE_RESET);
      st_q.addr  <= `SPM_ADDR_RESET;
      st_q.rdata <= 32'h0000_0000;
      st_q.err   <= 1'b0;
      st_q.phase <= spm_pkg::SPM_PH_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // zero wait states: every access phase completes at once
  assign o_pready  = i_psel && i_penable;
  assign o_pslverr = i_psel && i_penable && st_q.err;
  assign o_prdata  = st_q.rdata;

  // ---------------------------------------------------------------
  // serial port routing
  // ---------------------------------------------------------------
  // pins switch as soon as the field changes; no glitch-free handover,
  // so affected peripherals must be reset afterwards
  spm_serial_route u_sp0 (
    .i_mode     (st_q.sp0),
    .i_card     (i_card_drv[0]),
    .i_audio    (i_audio_drv[0]),
    .i_gp       (i_spgp_drv[0]),
    .i_pad_in   (i_sp_pad_in[0]),
    .o_pad      (o_sp_pad[0]),
    .o_card_in  (o_card_in[0]),
    .o_audio_in (o_audio_in[0]),
    .o_gp_in    (o_spgp_in[0])
  );

  spm_serial_route u_sp1 (
    .i_mode     (st_q.sp1),
    .i_card     (i_card_drv[1]),
    .i_audio    (i_audio_drv[1]),
    .i_gp       (i_spgp_drv[1]),
    .i_pad_in   (i_sp_pad_in[1]),
    .o_pad      (o_sp_pad[1]),
    .o_card_in  (o_card_in[1]),
    .o_audio_in (o_audio_in[1]),
    .o_gp_in    (o_spgp_in[1])
  );

  // ---------------------------------------------------------------
  // address pin routing
  // ---------------------------------------------------------------
  spm_addr_route #(
    .N (6)
  ) u_addr (
    .i_sel      (st_q.addr),
    .i_ema      (i_ema_hi),
    .i_ema_oe   (i_ema_oe),
    .i_gp_o     (i_adgp_drv.o),
    .i_gp_oe    (i_adgp_drv.oe),
    .i_pad_in   (i_addr_pad_in),
    .o_pad_o    (o_addr_pad.o),
    .o_pad_oe_n (o_addr_pad.oe_n),
    .o_gp_in    (o_adgp_in)
  );

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_sp1_card;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (st_q.sp1 == spm_pkg::SPM_ROUTE_CARD) |->
      (o_sp_pad[1].o == i_card_drv[1].o) && (o_sp_pad[1].oe_n == ~i_card_drv[1].oe)
      && (o_card_in[1] == i_sp_pad_in[1]);
  endproperty
  a_sp1_card: assert property (p_sp1_card) else $error("port 1 card route wrong");

  property p_sp1_audio;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (st_q.sp1 == spm_pkg::SPM_ROUTE_AUDIO) |->
      (o_sp_pad[1].o == {i_spgp_drv[1].o[5:4], i_audio_drv[1].o})
      && (o_audio_in[1] == i_sp_pad_in[1][3:0]) && (o_card_in[1] == 6'h00);
  endproperty
  a_sp1_audio: assert property (p_sp1_audio) else $error("port 1 audio route wrong");

  property p_sp1_gp;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (st_q.sp1 == spm_pkg::SPM_ROUTE_GP) |->
      (o_sp_pad[1].o == i_spgp_drv[1].o) && (o_spgp_in[1] == i_sp_pad_in[1]);
  endproperty
  a_sp1_gp: assert property (p_sp1_gp) else $error("port 1 gp route wrong");

  property p_sp0_card;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (st_q.sp0 == spm_pkg::SPM_ROUTE_CARD) |->
      (o_sp_pad[0].o == i_card_drv[0].o) && (o_sp_pad[0].oe_n == ~i_card_drv[0].oe);
  endproperty
  a_sp0_card: assert property (p_sp0_card) else $error("port 0 card route wrong");

  property p_sp0_audio;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (st_q.sp0 == spm_pkg::SPM_ROUTE_AUDIO) |->
      (o_sp_pad[0].oe_n == ~{i_spgp_drv[0].oe[5:4], i_audio_drv[0].oe})
      && (o_spgp_in[0][5:4] == i_sp_pad_in[0][5:4]);
  endproperty
  a_sp0_audio: assert property (p_sp0_audio) else $error("port 0 audio route wrong");

  property p_sp0_gp;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (st_q.sp0 == spm_pkg::SPM_ROUTE_GP) |->
      (o_sp_pad[0].o == i_spgp_drv[0].o) && (o_audio_in[0] == 4'h0);
  endproperty
  a_sp0_gp: assert property (p_sp0_gp) else $error("port 0 gp route wrong");

  property p_rsvd_read;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (setup && hit && !i_pwrite) |=>
      (o_prdata[31:12] == 20'h00000) && (o_prdata[7:6] == 2'h0);
  endproperty
  a_rsvd_read: assert property (p_rsvd_read) else $error("reserved bits read nonzero");

  property p_write_lands;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (wr_acc && (wr_sp1 != 2'h3)) |=>
      (st_q.sp1 == $past(wr_sp1)) && (st_q.addr == $past(i_pwdata[5:0]));
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("write did not land");

  property p_addr_ema;
    @(posedge i_mclk) disable iff (!i_rst_n)
    ((o_addr_pad.o & ~st_q.addr) == (i_ema_hi & ~st_q.addr))
      && ((o_adgp_in & ~st_q.addr) == 6'h00);
  endproperty
  a_addr_ema: assert property (p_addr_ema) else $error("address pin route wrong");

  property p_addr_gp;
    @(posedge i_mclk) disable iff (!i_rst_n)
    ((o_addr_pad.o & st_q.addr) == (i_adgp_drv.o & st_q.addr))
      && ((o_adgp_in & st_q.addr) == (i_addr_pad_in & st_q.addr));
  endproperty
  a_addr_gp: assert property (p_addr_gp) else $error("gp pin route wrong");

  property p_reset_clear;
    @(posedge i_mclk) disable iff (!i_rst_n)
    $rose(i_rst_n) |-> (sel_view == `SPM_SEL_RESET) && !o_pslverr;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("select not cleared");

  property p_ready_once;
    @(posedge i_mclk) disable iff (!i_rst_n)
    setup |=> (i_psel && i_penable) |-> (o_pready && (o_pslverr == !$past(hit)));
  endproperty
  a_ready_once: assert property (p_ready_once) else $error("access phase not ready");

  // reserved code must not disturb the stored route of that port
  property p_sp1_rsvd_kept;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (wr_acc && (wr_sp1 == 2'h3)) |=> (st_q.sp1 == $past(st_q.sp1));
  endproperty
  a_sp1_rsvd_kept: assert property (p_sp1_rsvd_kept) else $error("port 1 route lost");

  property p_sp0_rsvd_kept;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (wr_acc && (wr_sp0 == 2'h3)) |=> (st_q.sp0 == $past(st_q.sp0));
  endproperty
  a_sp0_rsvd_kept: assert property (p_sp0_rsvd_kept) else $error("port 0 route lost");

  property p_sp0_lands;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (wr_acc && (wr_sp0 != 2'h3)) |=> (st_q.sp0 == $past(wr_sp0));
  endproperty
  a_sp0_lands: assert property (p_sp0_lands) else $error("port 0 write lost");

  // a refused access must leave every route untouched
  property p_bad_addr_wr;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (i_psel && i_penable && i_pwrite && !hit) |=> $stable(sel_view);
  endproperty
  a_bad_addr_wr: assert property (p_bad_addr_wr) else $error("unmapped write landed");

  // read data stands from one setup until the next
  property p_prdata_stands;
    @(posedge i_mclk) disable iff (!i_rst_n)
    !setup |=> $stable(o_prdata);
  endproperty
  a_prdata_stands: assert property (p_prdata_stands) else $error("read data moved");

  // ---------------------------------------------------------------
  // scenario covers
  // ---------------------------------------------------------------
  property p_cv_sp1_audio;
    @(posedge i_mclk) disable iff (!i_rst_n)
    wr_acc ##1 (st_q.sp1 == spm_pkg::SPM_ROUTE_AUDIO);
  endproperty
  c_sp1_audio: cover property (p_cv_sp1_audio);

  property p_cv_sp0_gp;
    @(posedge i_mclk) disable iff (!i_rst_n)
    wr_acc ##1 (st_q.sp0 == spm_pkg::SPM_ROUTE_GP);
  endproperty
  c_sp0_gp: cover property (p_cv_sp0_gp);

  property p_cv_addr_all;
    @(posedge i_mclk) disable iff (!i_rst_n)
    (st_q.addr == 6'h3F);
  endproperty
  c_addr_all: cover property (p_cv_addr_all);

  property p_cv_slverr;
    @(posedge i_mclk) disable iff (!i_rst_n)
    o_pslverr;
  endproperty
  c_slverr: cover property (p_cv_slverr);

  property p_cv_rsvd_kept;
    @(posedge i_mclk) disable iff (!i_rst_n)
    wr_acc && (wr_sp1 == 2'h3) && (wr_sp0 == 2'h3);
  endproperty
  c_rsvd_kept: cover property (p_cv_rsvd_kept);

endmodule

// *** spm_params.svh ***
// register map, field positions and reset values of the pin select block
`ifndef SPM_PARAMS_SVH
`define SPM_PARAMS_SVH

`define SPM_SEL_OFFSET   12'h000
`define SPM_SEL_WIDTH    16
`define SPM_SP1_LSB      10
`define SPM_SP0_LSB      8
`define SPM_RSVD_LSB     6
`define SPM_ADDR_LSB     0
`define SPM_SEL_RESET    16'h0000
`define SPM_SEL_RDMASK   16'h0F3F
`define SPM_MODE_RESET   2'h0
`define SPM_ADDR_RESET   6'h00

`endif

// *** spm_pkg.sv ***
// types shared by the pin select block
package spm_pkg;

  typedef enum logic [1:0] {
    SPM_ROUTE_CARD  = 2'h0,
    SPM_ROUTE_AUDIO = 2'h1,
    SPM_ROUTE_GP    = 2'h2,
    SPM_ROUTE_RSVD  = 2'h3
  } spm_route_t;

  typedef enum logic {
    SPM_PH_IDLE,
    SPM_PH_ACCESS
  } spm_phase_t;

  // peripheral side drive: value and active-high enable
  typedef struct packed {
    logic [5:0] o;
    logic [5:0] oe;
  } spm_drv6_t;

  typedef struct packed {
    logic [3:0] o;
    logic [3:0] oe;
  } spm_drv4_t;

  // pad side drive: enable is low while driving
  typedef struct packed {
    logic [5:0] o;
    logic [5:0] oe_n;
  } spm_pad6_t;

  typedef struct packed {
    spm_route_t sp1;
    spm_route_t sp0;
    logic [5:0] addr;
    logic [31:0] rdata;
    logic        err;
    spm_phase_t  phase;
  } spm_state_t;

endpackage

// *** spm_serial_route.sv ***
// six-pin serial port router: card, audio plus two gp, or six gp
`timescale 1ns/100ps
module spm_serial_route (
  input  wire spm_pkg::spm_route_t i_mode,
  input  wire spm_pkg::spm_drv6_t  i_card,
  input  wire spm_pkg::spm_drv4_t  i_audio,
  input  wire spm_pkg::spm_drv6_t  i_gp,
  input  wire logic [5:0]          i_pad_in,
  output spm_pkg::spm_pad6_t       o_pad,
  output logic [5:0]               o_card_in,
  output logic [3:0]               o_audio_in,
  output logic [5:0]               o_gp_in
);

  always_comb begin
    o_pad      = '{o: 6'h00, oe_n: 6'h3F};
    o_card_in  = 6'h00;
    o_audio_in = 4'h0;
    o_gp_in    = 6'h00;
    case (i_mode)
      spm_pkg::SPM_ROUTE_CARD: begin
        o_pad.o    = i_card.o;
        o_pad.oe_n = ~i_card.oe;
        o_card_in  = i_pad_in;
      end
      spm_pkg::SPM_ROUTE_AUDIO: begin
        o_pad.o    = {i_gp.o[5:4], i_audio.o};
        o_pad.oe_n = ~{i_gp.oe[5:4], i_audio.oe};
        o_audio_in = i_pad_in[3:0];
        o_gp_in    = {i_pad_in[5:4], 4'h0};
      end
      spm_pkg::SPM_ROUTE_GP: begin
        o_pad.o    = i_gp.o;
        o_pad.oe_n = ~i_gp.oe;
        o_gp_in    = i_pad_in;
      end
      // reserved code: pads released, nothing connected
      default: begin
        o_pad.o    = 6'h00;
      end
    endcase
  end

endmodule

// *** spm_addr_route.sv ***
// upper address pins: each one either external address or gp
`timescale 1ns/100ps
module spm_addr_route #(
  parameter int unsigned N = 6
) (
  input  wire logic [N-1:0] i_sel,
  input  wire logic [N-1:0] i_ema,
  input  wire logic         i_ema_oe,
  input  wire logic [N-1:0] i_gp_o,
  input  wire logic [N-1:0] i_gp_oe,
  input  wire logic [N-1:0] i_pad_in,
  output logic [N-1:0]      o_pad_o,
  output logic [N-1:0]      o_pad_oe_n,
  output logic [N-1:0]      o_gp_in
);

  for (genvar g = 0; g < N; g++) begin : g_pin
    always_comb begin
      if (i_sel[g]) begin
        o_pad_o[g]    = i_gp_o[g];
        o_pad_oe_n[g] = ~i_gp_oe[g];
        o_gp_in[g]    = i_pad_in[g];
      end else begin
        o_pad_o[g]    = i_ema[g];
        o_pad_oe_n[g] = ~i_ema_oe;
        o_gp_in[g]    = 1'b0;
      end
    end
  end

endmodule

// *** tb_spm_pin_mux.sv ***
// self-checking bench for the pin select block with a reference model
`timescale 1ns/100ps
module tb_spm_pin_mux;
  // ------------------------------------------------------------
  // design ports and bench state
  // ------------------------------------------------------------
  logic               i_mclk = 1'b0;
  logic               i_rst_n = 1'b0;
  logic               i_psel = 1'b0;
  logic               i_penable = 1'b0;
  logic               i_pwrite = 1'b0;
  logic [11:0]        i_paddr = 12'h000;
  logic [31:0]        i_pwdata = 32'h00000000;
  logic [31:0]        o_prdata;
  logic               o_pready;
  logic               o_pslverr;
  spm_pkg::spm_drv6_t i_card_drv [2];
  logic [5:0]         o_card_in [2];
  spm_pkg::spm_drv4_t i_audio_drv [2];
  logic [3:0]         o_audio_in [2];
  spm_pkg::spm_drv6_t i_spgp_drv [2];
  logic [5:0]         o_spgp_in [2];
  spm_pkg::spm_pad6_t o_sp_pad [2];
  logic [5:0]         i_sp_pad_in [2];
  logic [5:0]         i_ema_hi = 6'h00;
  logic               i_ema_oe = 1'b0;
  spm_pkg::spm_drv6_t i_adgp_drv = 12'h000;
  logic [5:0]         o_adgp_in;
  spm_pkg::spm_pad6_t o_addr_pad;
  logic [5:0]         i_addr_pad_in = 6'h00;
  int                 fail_count = 0;
  int                 n_compared = 0;
  integer             seed = 32'hD6055B6E;
  int                 m_sp1;
  int                 m_sp0;
  logic [5:0]         m_addr;

  always #12.5 i_mclk = ~i_mclk;

  spm_pin_mux #(.AW(12)) dut_u (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_card_drv(i_card_drv),
    .o_card_in(o_card_in), .i_audio_drv(i_audio_drv), .o_audio_in(o_audio_in),
    .i_spgp_drv(i_spgp_drv), .o_spgp_in(o_spgp_in), .o_sp_pad(o_sp_pad),
    .i_sp_pad_in(i_sp_pad_in), .i_ema_hi(i_ema_hi), .i_ema_oe(i_ema_oe),
    .i_adgp_drv(i_adgp_drv), .o_adgp_in(o_adgp_in), .o_addr_pad(o_addr_pad),
    .i_addr_pad_in(i_addr_pad_in)
  );

  // ------------------------------------------------------------
  // compare, verdict and bus tasks
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask

  task automatic end_sim();
    if (fail_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // waits on pready rather than assuming zero wait states
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int k;
    @(posedge i_mclk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_mclk);
    i_penable <= 1'b1;
    k = 0;
    do begin
      @(posedge i_mclk);
      k++;
    end while (o_pready !== 1'b1 && k < 16);
    if (o_pready !== 1'b1) begin
      $display("CHECK FAILED pready expected 1 seen %b", o_pready);
      fail_count++;
      end_sim();
    end else begin
      rd = o_prdata;
      err = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
    end
  endtask

  function automatic logic [31:0] exp_reg();
    return {20'h00000, 2'(m_sp1), 2'(m_sp0), 2'h0, m_addr};
  endfunction

  task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, rd, err);
    chk("write error flag", 32'(a != 12'h000), 32'(err));
    if (a == 12'h000) begin
      if (d[11:10] != 2'h3) m_sp1 = int'(d[11:10]);
      if (d[9:8] != 2'h3) m_sp0 = int'(d[9:8]);
      m_addr = d[5:0];
    end
  endtask

  task automatic reg_rd(input logic [11:0] a);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'($random(seed)), rd, err);
    chk("read data", (a == 12'h000) ? exp_reg() : 32'h00000000, rd);
    chk("read error flag", 32'(a != 12'h000), 32'(err));
  endtask

  // fresh random drives each time so a stuck or swapped lane shows
  task automatic check_pins();
    logic [5:0] o;
    logic [5:0] oe;
    logic [5:0] p;
    int         m;
    @(posedge i_mclk);
    for (int n = 0; n < 2; n++) begin
      i_card_drv[n] <= 12'($random(seed));
      i_audio_drv[n] <= 8'($random(seed));
      i_spgp_drv[n] <= 12'($random(seed));
      i_sp_pad_in[n] <= 6'($random(seed));
    end
    i_ema_hi <= 6'($random(seed));
    i_ema_oe <= 1'($random(seed));
    i_adgp_drv <= 12'($random(seed));
    i_addr_pad_in <= 6'($random(seed));
    #1;
    for (int n = 0; n < 2; n++) begin
      m = (n == 1) ? m_sp1 : m_sp0;
      p = i_sp_pad_in[n];
      o = (m == 0) ? i_card_drv[n].o : i_spgp_drv[n].o;
      oe = (m == 0) ? i_card_drv[n].oe : i_spgp_drv[n].oe;
      if (m == 1) begin
        o = {i_spgp_drv[n].o[5:4], i_audio_drv[n].o};
        oe = {i_spgp_drv[n].oe[5:4], i_audio_drv[n].oe};
      end
      chk("serial pad", 32'({o, ~oe}), 32'(o_sp_pad[n]));
      chk("card input", 32'((m == 0) ? p : 6'h00), 32'(o_card_in[n]));
      chk("audio input", 32'((m == 1) ? p[3:0] : 4'h0), 32'(o_audio_in[n]));
      o = (m == 2) ? p : ((m == 1) ? {p[5:4], 4'h0} : 6'h00);
      chk("gp input", 32'(o), 32'(o_spgp_in[n]));
    end
    for (int i = 0; i < 6; i++) begin
      o[i] = m_addr[i] ? i_adgp_drv.o[i] : i_ema_hi[i];
      oe[i] = m_addr[i] ? i_adgp_drv.oe[i] : i_ema_oe;
    end
    chk("address pad", 32'({o, ~oe}), 32'(o_addr_pad));
    chk("address gp input", 32'(m_addr & i_addr_pad_in), 32'(o_adgp_in));
  endtask

  task automatic do_reset();
    @(posedge i_mclk);
    i_rst_n <= 1'b0;
    repeat (6) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    m_sp1 = 0;
    m_sp0 = 0;
    m_addr = 6'h00;
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    logic [31:0] d;
    for (int n = 0; n < 2; n++) begin
      i_card_drv[n] = 12'h000;
      i_audio_drv[n] = 8'h00;
      i_spgp_drv[n] = 12'h000;
      i_sp_pad_in[n] = 6'h00;
    end
    do_reset();
    reg_rd(12'h000);
    check_pins();
    // every legal pairing of the two port modes, upper and reserved bits random
    for (int i = 0; i < 9; i++) begin
      d = $random(seed);
      d[11:8] = {2'(i / 3), 2'(i % 3)};
      reg_wr(12'h000, d);
      check_pins();
      reg_rd(12'h000);
    end
    reg_wr(12'h000, 32'h00000D2A);
    check_pins();
    reg_rd(12'h000);
    reg_wr(12'h000, 32'hFFFF0BC5);
    reg_rd(12'h000);
    reg_wr(12'h000, 32'h00000F3F);
    check_pins();
    reg_rd(12'h000);
    reg_wr(12'h004, 32'hFFFFFFFF);
    reg_rd(12'h004);
    reg_rd(12'hFFC);
    reg_rd(12'h000);
    do_reset();
    reg_rd(12'h000);
    check_pins();
    for (int i = 0; i < 20; i++) begin
      reg_wr(12'h000, $random(seed));
      check_pins();
      reg_rd(12'h000);
    end
    end_sim();
  end
endmodule
